// ===== pkg/ubc_regs.svh
// Register map, field positions and reset values of the up/down counter block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef UBC_REGS_SVH
`define UBC_REGS_SVH

`define UBC_ADDR_W          4
`define UBC_DATA_W          32
`define UBC_CNT_W           4
`define UBC_CNT_MAX         4'hf
`define UBC_CNT_MIN         4'h0
`define UBC_CNT_ONE         4'h1

`define UBC_OFS_CTRL        4'h0
`define UBC_OFS_PRESET      4'h4
`define UBC_OFS_STATUS      4'h8

`define UBC_CTRL_INHIBIT    0
`define UBC_STAT_TERM       4
`define UBC_STAT_DIR        5
`define UBC_STAT_LOAD       6

`define UBC_CTRL_RST        1'h0
`define UBC_PRESET_RST      4'h0
`define UBC_COUNT_RST       4'h0

`endif

// ===== pkg/ubc_pkg.sv
// Types shared by the up/down counter block.
// Constants live in ubc_regs.svh; this package holds types only.
package ubc_pkg;

    typedef logic [3:0] ubc_count_t;

    typedef enum logic {
        UBC_UP,
        UBC_DOWN
    } ubc_dir_t;

endpackage

// ===== core/ubc_counter.sv
// Four-bit up/down counter with preset, count enable, terminal flag and
// ripple clock, plus an Avalon-MM slave for control and status.
// Assumes all counter pins are asynchronous to i_clk, including clock_in.
`timescale 1ns/1ps
`include "ubc_regs.svh"

module ubc_counter (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic [3:0]               i_preset_value_in,
    input  wire logic                     i_load_n,
    input  wire logic                     i_count_enable_n,
    input  wire logic                     i_direction,
    input  wire logic                     i_clock_in,
    output logic      [3:0]               o_count_value_out,
    output logic                          o_terminal_flag,
    output logic                          o_ripple_clock_n,
    input  wire logic [`UBC_ADDR_W-1:0]   i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [`UBC_DATA_W-1:0]   i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic      [`UBC_DATA_W-1:0]   o_avs_readdata,
    output logic                          o_avs_waitrequest
);

    // Pin synchronisers: stage one is read only by stage two
    logic [3:0]        preset_m_r;
    logic [3:0]        preset_s_r;
    logic [3:0]        pin_m_r;
    logic [3:0]        pin_s_r;
    logic              clk_d_r;
    logic              load_n_s;
    logic              en_n_s;
    logic              dir_s;
    logic              clk_s;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            preset_m_r <= 4'h0;
            preset_s_r <= 4'h0;
            pin_m_r    <= 4'hb;
            pin_s_r    <= 4'hb;
        end else begin
            preset_m_r <= i_preset_value_in;
            preset_s_r <= preset_m_r;
            pin_m_r    <= {i_clock_in, i_direction, i_count_enable_n, i_load_n};
            pin_s_r    <= pin_m_r;
        end
    end

    assign load_n_s = pin_s_r[0];
    assign en_n_s   = pin_s_r[1];
    assign dir_s    = pin_s_r[2];
    assign clk_s    = pin_s_r[3];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_d_r <= 1'b1;
        end else begin
            clk_d_r <= clk_s;
        end
    end

    // Software registers
    logic              inhibit_r;
    ubc_pkg::ubc_count_t preset_reg_r;
    logic              sw_load_r;
    logic              ack_r;
    logic              req;
    logic              wr_take;
    logic              rd_take;

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_r;
    assign wr_take           = i_avs_write & ack_r & i_avs_byteenable[0];
    assign rd_take           = i_avs_read & ~ack_r;

    // One wait cycle on every access keeps read data registered
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            inhibit_r    <= `UBC_CTRL_RST;
            preset_reg_r <= `UBC_PRESET_RST;
            sw_load_r    <= 1'b0;
        end else begin
            sw_load_r <= 1'b0;
            if (wr_take && i_avs_address == `UBC_OFS_CTRL) begin
                inhibit_r <= i_avs_writedata[`UBC_CTRL_INHIBIT];
            end
            if (wr_take && i_avs_address == `UBC_OFS_PRESET) begin
                preset_reg_r <= i_avs_writedata[3:0];
                sw_load_r    <= 1'b1;
            end
        end
    end

    // Counter core
    ubc_pkg::ubc_count_t count_r;
    ubc_pkg::ubc_count_t count_nxt;
    ubc_pkg::ubc_dir_t   dir_r;
    logic              rise;
    logic              en_n_eff;
    logic              term_nxt;
    logic              ripple_nxt;

    // Software inhibit acts as a held-high enable, so it also blocks ripple
    assign en_n_eff = en_n_s | inhibit_r;
    assign rise     = clk_s & ~clk_d_r;

    function automatic logic term_decode(input ubc_pkg::ubc_count_t c, input logic down);
        term_decode = down ? (c == `UBC_CNT_MIN) : (c == `UBC_CNT_MAX);
    endfunction

    always_comb begin
        count_nxt = count_r;
        if (!load_n_s) begin
            count_nxt = preset_s_r;
        end else if (sw_load_r) begin
            count_nxt = preset_reg_r;
        end else if (rise && !en_n_eff) begin
            if (dir_s) begin
                count_nxt = count_r - `UBC_CNT_ONE;
            end else begin
                count_nxt = count_r + `UBC_CNT_ONE;
            end
        end
    end

    // Reset value stands in for the undefined power-up count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_r <= `UBC_COUNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_r <= ubc_pkg::UBC_UP;
        end else begin
            dir_r <= dir_s ? ubc_pkg::UBC_DOWN : ubc_pkg::UBC_UP;
        end
    end

    // Flag decoded from the next count so it lines up with the count output
    assign term_nxt   = term_decode(count_nxt, dir_s);
    assign ripple_nxt = ~(term_nxt & ~en_n_eff & ~clk_s);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_terminal_flag  <= 1'b0;
            o_ripple_clock_n <= 1'b1;
        end else begin
            o_terminal_flag  <= term_nxt;
            o_ripple_clock_n <= ripple_nxt;
        end
    end

    assign o_count_value_out = count_r;

    // Read path
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            o_avs_readdata <= 32'h0000_0000;
            unique case (i_avs_address)
                `UBC_OFS_CTRL: begin
                    o_avs_readdata[`UBC_CTRL_INHIBIT] <= inhibit_r;
                end
                `UBC_OFS_PRESET: begin
                    o_avs_readdata[3:0] <= preset_reg_r;
                end
                `UBC_OFS_STATUS: begin
                    o_avs_readdata[3:0]             <= count_r;
                    o_avs_readdata[`UBC_STAT_TERM]  <= o_terminal_flag;
                    o_avs_readdata[`UBC_STAT_DIR]   <= dir_r == ubc_pkg::UBC_DOWN;
                    o_avs_readdata[`UBC_STAT_LOAD]  <= load_n_s;
                end
                default: begin
                    o_avs_readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Helper for the ripple check: counts how long the enabled low phase has lasted with the flag up
    logic [3:0]        low_run_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            low_run_r <= 4'h0;
        end else if (term_nxt && !en_n_eff && !clk_s) begin
            low_run_r <= (low_run_r == 4'hf) ? low_run_r : low_run_r + 4'h1;
        end else begin
            low_run_r <= 4'h0;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    load_copy_a: assert property (!load_n_s |=> count_r == $past(preset_s_r))
        else $error("count did not take the preset while load was low");

    load_prio_a: assert property (!load_n_s && rise && !en_n_eff |=> count_r == $past(preset_s_r))
        else $error("clock edge changed the count during load");

    hold_inh_a: assert property (load_n_s && en_n_eff && !sw_load_r |=> count_r == $past(count_r))
        else $error("count moved while enable was high");

    edge_only_a: assert property (load_n_s && !rise && !sw_load_r |=> count_r == $past(count_r))
        else $error("count moved without a rising clock_in");

    count_up_a: assert property (load_n_s && !sw_load_r && rise && !en_n_eff && !dir_s
        |=> count_r == 4'($past(count_r) + `UBC_CNT_ONE))
        else $error("up count did not add one");

    count_down_a: assert property (load_n_s && !sw_load_r && rise && !en_n_eff && dir_s
        |=> count_r == 4'($past(count_r) - `UBC_CNT_ONE))
        else $error("down count did not subtract one");

    term_flag_a: assert property (o_terminal_flag
        == (dir_r == ubc_pkg::UBC_DOWN ? count_r == `UBC_CNT_MIN : count_r == `UBC_CNT_MAX))
        else $error("terminal flag does not match count and direction");

    term_hold_a: assert property ($past(o_terminal_flag) && $stable(count_r) && $stable(dir_r)
        |-> o_terminal_flag)
        else $error("terminal flag dropped with count and direction unchanged");

    ripple_low_a: assert property (o_terminal_flag && !en_n_eff && !clk_s
        ##1 !en_n_eff && !clk_s && load_n_s |-> !o_ripple_clock_n)
        else $error("ripple clock did not follow clock_in low");

    ripple_inh_a: assert property (en_n_eff |=> o_ripple_clock_n)
        else $error("ripple clock pulsed while enable was high");

    ripple_rise_a: assert property (clk_s |=> o_ripple_clock_n)
        else $error("ripple clock stayed low after clock_in rose");

    // Flag checks use the registered direction, which lines up with the count output
    term_low_a: assert property (count_r != `UBC_CNT_MIN && count_r != `UBC_CNT_MAX
        |-> !o_terminal_flag)
        else $error("terminal flag high away from both ends");

    term_max_a: assert property (count_r == `UBC_CNT_MAX && dir_r == ubc_pkg::UBC_UP
        |-> o_terminal_flag)
        else $error("terminal flag low at fifteen counting up");

    term_min_a: assert property (count_r == `UBC_CNT_MIN && dir_r == ubc_pkg::UBC_DOWN
        |-> o_terminal_flag)
        else $error("terminal flag low at zero counting down");

    term_noen_a: assert property ($changed(en_n_eff) && $stable(count_r) && $stable(dir_r)
        |-> $stable(o_terminal_flag))
        else $error("terminal flag followed the count enable");

    load_hold_a: assert property (!load_n_s && !$past(load_n_s) && $stable(preset_s_r)
        |=> $stable(count_r))
        else $error("count moved while load held a steady preset");

    step_one_a: assert property (load_n_s && !sw_load_r
        |=> count_r == $past(count_r) || count_r == 4'($past(count_r) + `UBC_CNT_ONE)
            || count_r == 4'($past(count_r) - `UBC_CNT_ONE))
        else $error("count jumped by more than one without a load");

    ripple_src_a: assert property (!o_ripple_clock_n
        |-> $past(term_nxt) && !$past(en_n_eff) && !$past(clk_s))
        else $error("ripple clock low without flag, enable and low clock_in");

    ripple_flag_a: assert property (!o_ripple_clock_n |-> o_terminal_flag)
        else $error("ripple clock low while terminal flag low");

    ripple_run_a: assert property (low_run_r != 4'h0 |-> !o_ripple_clock_n)
        else $error("ripple clock high during an enabled low phase");

    inhibit_rip_a: assert property (inhibit_r |=> o_ripple_clock_n)
        else $error("ripple clock pulsed under software inhibit");

    sw_load_a: assert property (sw_load_r && load_n_s |=> count_r == $past(preset_reg_r))
        else $error("software preset did not reach the count");

    // Bus checks: one wait state on every access keeps read data registered
    wait_once_a: assert property (req && !ack_r |=> !req || !o_avs_waitrequest)
        else $error("waitrequest held for more than one cycle");

    wr_lane_a: assert property (i_avs_write && ack_r && !i_avs_byteenable[0]
        |=> $stable(inhibit_r) && $stable(preset_reg_r))
        else $error("write landed with byte lane zero disabled");

    rd_status_a: assert property (rd_take && i_avs_address == `UBC_OFS_STATUS
        |=> o_avs_readdata[3:0] == $past(count_r))
        else $error("status read did not return the count");

    rd_ctrl_a: assert property (rd_take && i_avs_address == `UBC_OFS_CTRL
        |=> o_avs_readdata == 32'($past(inhibit_r)))
        else $error("control read did not return the inhibit bit");

    rd_preset_a: assert property (rd_take && i_avs_address == `UBC_OFS_PRESET
        |=> o_avs_readdata == 32'($past(preset_reg_r)))
        else $error("preset read did not return the stored value");

    rd_hole_a: assert property (rd_take && i_avs_address != `UBC_OFS_CTRL
        && i_avs_address != `UBC_OFS_PRESET && i_avs_address != `UBC_OFS_STATUS
        |=> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    up_wrap_c: cover property (count_r == `UBC_CNT_MAX && !dir_s ##1 count_r == `UBC_CNT_MIN);
    down_wrap_c: cover property (count_r == `UBC_CNT_MIN && dir_s ##1 count_r == `UBC_CNT_MAX);
    pin_load_c: cover property (!load_n_s ##1 load_n_s);
    ripple_c: cover property (!o_ripple_clock_n ##1 o_ripple_clock_n);
    term_hold_c: cover property (o_terminal_flag && en_n_eff);

endmodule

// ===== verification/ubc_pin_driver.sv
// Stand-in for the control logic that drives the counter pins.
// Assumes one caller at a time, each task entered just after an i_clk edge.
`timescale 1ns/1ps
module ubc_pin_driver (
    input  wire logic       i_clk,
    input  wire logic       i_ripple_clock_n,
    output logic [3:0]      o_preset_value_in,
    output logic            o_load_n,
    output logic            o_count_enable_n,
    output logic            o_direction,
    output logic            o_clock_in
);
    // Terminal flag is not wired in: it may glitch, so nothing is clocked from it
    initial begin
        o_preset_value_in = 4'h5;
        o_load_n = 1'b1;
        o_count_enable_n = 1'b1;
        o_direction = 1'b0;
        o_clock_in = 1'b1;
    end
    // Pin effects land three edges late, so wait one more
    task automatic settle();
        repeat (4) @(posedge i_clk);
    endtask
    // Clock idles high between ticks, so both changes fall in its high phase
    task automatic set_dir(input logic d);
        o_direction <= d;
        settle();
    endtask
    // Lone stage: its enable is just the inhibit term of a look-ahead carry gate
    task automatic set_en(input logic e_n);
        o_count_enable_n <= e_n;
        settle();
    endtask
    // Released preset lines show the inverse so a stale value is not mistaken for data
    task automatic set_load(input logic l_n, input logic [3:0] d);
        o_load_n <= l_n;
        o_preset_value_in <= l_n ? ~d : d;
        settle();
    endtask
    task automatic tick(output logic rc_n);
        o_clock_in <= 1'b0;
        // Low phase outlasts the ripple path from flag to ripple clock
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        rc_n = i_ripple_clock_n;
        @(posedge i_clk);
        o_clock_in <= 1'b1;
        settle();
    endtask
endmodule

// ===== verification/updown_binary_counter4_tb.sv
// Bench for the up/down counter: pin scenarios and register access.
// Assumes ubc_pin_driver owns the counter pins and this module the bus.
`timescale 1ns/1ps
`include "ubc_regs.svh"
module updown_binary_counter4_tb;
    logic        clk;
    logic        rst;
    logic [3:0]  pv, cnt, be;
    logic        ld_n, en_n, dir, cin, rc_n, tf, rcl;
    logic        rd, wr, wq;
    logic [`UBC_ADDR_W-1:0] addr;
    logic [31:0] wd, rdat, v;
    int          mismatches, num_checks, cyc;

    ubc_counter i_dut (.i_clk(clk), .i_rst(rst), .i_preset_value_in(pv), .i_load_n(ld_n),
        .i_count_enable_n(en_n), .i_direction(dir), .i_clock_in(cin), .o_count_value_out(cnt),
        .o_terminal_flag(tf), .o_ripple_clock_n(rc_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq));
    ubc_pin_driver i_drv (.i_clk(clk), .i_ripple_clock_n(rc_n), .o_preset_value_in(pv),
        .o_load_n(ld_n), .o_count_enable_n(en_n), .o_direction(dir), .o_clock_in(cin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Read data lands at the rising edge that sees waitrequest high, the write at the next one that sees it low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        rd <= !w;
        wr <= w;
        addr <= a;
        wd <= d;
        be <= b;
        @(posedge clk);
        while (wq)
            @(posedge clk);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_regs();
        bus(0, `UBC_OFS_CTRL, 0, 4'hf);
        chk("ctrl reset", 32'h0, v);
        bus(0, `UBC_OFS_STATUS, 0, 4'hf);
        chk("status reset", 32'h40, v);
        bus(0, 4'hc, 0, 4'hf);
        chk("unmapped read", 32'h0, v);
        bus(1, `UBC_OFS_CTRL, 32'h1, 4'h0);
        bus(0, `UBC_OFS_CTRL, 0, 4'hf);
        chk("ctrl lane off", 32'h0, v);
        bus(1, `UBC_OFS_PRESET, 32'h9, 4'hf);
        bus(0, `UBC_OFS_PRESET, 0, 4'hf);
        chk("preset readback", 32'h9, v);
        chk("preset load", 32'h9, {28'h0, cnt});
    endtask

    task automatic t_load();
        i_drv.set_load(1'b0, 4'he);
        chk("pin load", 32'he, {28'h0, cnt});
        i_drv.set_en(1'b0);
        i_drv.tick(rcl);
        chk("load over count", 32'he, {28'h0, cnt});
        i_drv.set_load(1'b1, 4'he);
    endtask

    task automatic t_up_down();
        i_drv.tick(rcl);
        chk("count up", 32'hf, {28'h0, cnt});
        chk("flag up", 32'h1, {31'h0, tf});
        i_drv.tick(rcl);
        chk("ripple low", 32'h0, {31'h0, rcl});
        chk("wrap up", 32'h0, {28'h0, cnt});
        chk("flag cleared", 32'h0, {31'h0, tf});
        chk("ripple back", 32'h1, {31'h0, rc_n});
        i_drv.set_dir(1'b1);
        chk("flag down", 32'h1, {31'h0, tf});
        i_drv.tick(rcl);
        chk("wrap down", 32'hf, {28'h0, cnt});
        i_drv.set_dir(1'b0);
        chk("flag on dir", 32'h1, {31'h0, tf});
    endtask

    task automatic t_hold();
        i_drv.set_en(1'b1);
        chk("flag no enable", 32'h1, {31'h0, tf});
        i_drv.tick(rcl);
        chk("ripple blocked", 32'h1, {31'h0, rcl});
        chk("hold count", 32'hf, {28'h0, cnt});
        i_drv.set_dir(1'b1);
        i_drv.set_en(1'b0);
        bus(1, `UBC_OFS_CTRL, 32'h1, 4'hf);
        i_drv.tick(rcl);
        chk("inhibit", 32'hf, {28'h0, cnt});
        bus(1, `UBC_OFS_CTRL, 32'h0, 4'hf);
        i_drv.tick(rcl);
        bus(0, `UBC_OFS_STATUS, 0, 4'hf);
        chk("status down", 32'h6e, v);
    endtask

    // Mid-run reset with the direction pin high: flag must come back up at count zero
    task automatic t_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset count", 32'h0, {28'h0, cnt});
        chk("reset ripple", 32'h1, {31'h0, rc_n});
        rst <= 1'b0;
        i_drv.settle();
        chk("flag after reset", 32'h1, {31'h0, tf});
        bus(0, `UBC_OFS_STATUS, 0, 4'hf);
        chk("status after reset", 32'h70, v);
        bus(0, `UBC_OFS_CTRL, 0, 4'hf);
        chk("ctrl after reset", 32'h0, v);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        be = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_load();
        t_up_down();
        t_hold();
        t_reset();
        final_report();
    end
endmodule
